// *** hdl/remote_cmd_pkg.sv ***
// constants, types and register map of the remote keypad command decoder
// Contract
// - preselect key toggles its lamp; second press clears lamps and aborts input
// - lift select then raise re-enables automatic lift mode when parameterised
// - manual lift parameter: lift select plus raise/lower just moves lift axle
// - lift select then memory one starts traction help in automatic mode only; here it is gated by the auto-lift parameter, not by auto_lift_out
// - stop key cancels traction help, also one started from towing vehicle
// - with levels enabled and an axle preselected, decode levels I, II, III
// - last selected driving level stays current until another is chosen
// - brief driving-level key press alone goes to the current driving level
// - stop plus memory key saves the reference level into that slot
// - memory slots survive ignition-off and need any one axle preselected; storing into a slot checks no preselection here
// - memory key alone starts moving to the stored level at once
// - stop halts all levelling and takes measured level as reference
// - ignition off while stop held enters standby on trailer battery
// - raise/lower and memory accepted only at or below operating speed
// - manual lift commands rejected above the lift-axle speed limit
// - unrecognised multi-key combination accepts nothing and performs stop
// - keypad unplugged triggers stop at once
// - later firmware lets a level change in progress continue on unplug
// - keypad raise/lower overrides an active unloading level
// - bridged data and clock means no keypad; level I right at ignition-on
// - not bridged: level I only once speed exceeds the return speed
// - warning lamp off, flashing on system failure, on for level fault
package remote_cmd_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SPEED = 8'h04;
  localparam logic [7:0] REG_LIMITS = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_MEM = 8'h10;
  localparam logic [7:0] REG_EVENT = 8'h14;
  // control register fields
  localparam int CTRL_AUTO_LIFT = 0;
  localparam int CTRL_LEVELS_EN = 1;
  localparam int CTRL_LATE_FW = 2;
  localparam int CTRL_SYS_FAIL = 3;
  localparam int CTRL_DL_FAULT = 4;
  localparam int CTRL_UNLOAD = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [23:0] LIMITS_RESET = 24'h0A1E0A;
  // key bit positions in a keypad frame, sent lowest bit first
  localparam int KEY_BITS = 9;
  localparam int K_FRONT = 0;
  localparam int K_REAR = 1;
  localparam int K_LIFT = 2;
  localparam int K_RAISE = 3;
  localparam int K_LOWER = 4;
  localparam int K_STOP = 5;
  localparam int K_M1 = 6;
  localparam int K_M2 = 7;
  localparam int K_DL = 8;
  // timing, figures in ns and derived cycle counts at 5 ns
  localparam int CLK_PS = 5000;
  localparam int GAP_NS = 1000;
  localparam int COMBO_NS = 20000;
  localparam int BRIDGE_NS = 10000;
  localparam int LOSS_NS = 100000;
  localparam int FLASH_NS = 250000000;
  localparam int GAP_CYC = (GAP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int COMBO_CYC = (COMBO_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int BRIDGE_CYC = (BRIDGE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int LOSS_CYC = (LOSS_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int FLASH_CYC = int'((64'(FLASH_NS) * 64'd1000) / 64'(CLK_PS));
  // commands issued to the levelling logic
  typedef enum logic [3:0] {
    OP_NONE, OP_STOP, OP_DRIVE_LEVEL, OP_MEM_RECALL, OP_MEM_STORE,
    OP_LIFT_UP, OP_LIFT_DOWN, OP_AUTO_ON, OP_TRACTION_ON, OP_STANDBY
  } op_t;
  typedef struct packed {
    logic valid;
    op_t op;
    logic [7:0] arg;
  } cmd_t;
  typedef enum logic [1:0] {KS_IDLE, KS_COLLECT, KS_HELD} key_state_t;
endpackage : remote_cmd_pkg

// *** hdl/suspension_remote_command_decoder.sv ***
// keypad link receiver, key combination decoder and register slave
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
module suspension_remote_command_decoder
  import remote_cmd_pkg::*;
#(
  parameter int LOSS_CYCLES = LOSS_CYC,
  parameter int FLASH_CYCLES = FLASH_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic keypad_data_in,
  input wire logic keypad_clk_in,
  input wire logic ignition_in,
  input wire logic [7:0] level_in,
  input wire logic level_done_in,
  output cmd_t cmd_out,
  output logic [2:0] preselect_lamp_out,
  output logic raise_hold_out,
  output logic lower_hold_out,
  output logic traction_out,
  output logic auto_lift_out,
  output logic standby_out,
  output logic warning_lamp_out
);
  localparam logic [8:0] KM_FRONT = 9'h001;
  localparam logic [8:0] KM_REAR = 9'h002;
  localparam logic [8:0] KM_LIFT = 9'h004;
  localparam logic [8:0] KM_RAISE = 9'h008;
  localparam logic [8:0] KM_LOWER = 9'h010;
  localparam logic [8:0] KM_STOP = 9'h020;
  localparam logic [8:0] KM_M1 = 9'h040;
  localparam logic [8:0] KM_M2 = 9'h080;
  localparam logic [8:0] KM_DL = 9'h100;

  // two-stage synchronisers for pins
  logic [1:0] dat_sync_ff, clk_sync_ff, ign_sync_ff;
  logic clk_prev_ff, ign_prev_ff;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      dat_sync_ff <= 2'h0;
      clk_sync_ff <= 2'h0;
      ign_sync_ff <= 2'h0;
      clk_prev_ff <= 1'b0;
      ign_prev_ff <= 1'b0;
    end else begin
      dat_sync_ff <= {dat_sync_ff[0], keypad_data_in};
      clk_sync_ff <= {clk_sync_ff[0], keypad_clk_in};
      ign_sync_ff <= {ign_sync_ff[0], ignition_in};
      clk_prev_ff <= clk_sync_ff[1];
      ign_prev_ff <= ign_sync_ff[1];
    end
  end
  wire key_dat = dat_sync_ff[1];
  wire key_clk = clk_sync_ff[1];
  wire ign_on = ign_sync_ff[1];
  wire clk_rise = key_clk & ~clk_prev_ff;
  wire ign_rise = ign_on & ~ign_prev_ff;
  wire ign_fall = ~ign_on & ign_prev_ff;

  // frame receiver: bits on keypad clock rising edges, ninth bit ends a frame, idle gap drops a partial one
  logic [8:0] shift_ff;
  logic [3:0] bit_cnt_ff;
  logic [15:0] gap_cnt_ff;
  logic frame_ff;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      shift_ff <= 9'h000;
      bit_cnt_ff <= 4'h0;
      gap_cnt_ff <= 16'h0000;
      frame_ff <= 1'b0;
    end else begin
      frame_ff <= 1'b0;
      if (clk_rise) begin
        gap_cnt_ff <= 16'h0000;
        shift_ff <= {key_dat, shift_ff[8:1]};
        if (bit_cnt_ff == 4'(KEY_BITS - 1)) begin
          bit_cnt_ff <= 4'h0;
          frame_ff <= 1'b1;
        end else begin
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end
      end else if (gap_cnt_ff == 16'(GAP_CYC)) begin
        bit_cnt_ff <= 4'h0; // partial frame dropped
      end else begin
        gap_cnt_ff <= gap_cnt_ff + 16'h0001;
      end
    end
  end

  // presence and bridged-line detection
  logic [31:0] loss_cnt_ff;
  logic [15:0] bridge_cnt_ff;
  logic present_ff, bridged_ff;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      loss_cnt_ff <= 32'h0000_0000;
      bridge_cnt_ff <= 16'h0000;
      present_ff <= 1'b0;
      bridged_ff <= 1'b0;
    end else begin
      if (frame_ff) begin
        loss_cnt_ff <= 32'h0000_0000;
        present_ff <= 1'b1;
      end else if (loss_cnt_ff == 32'(LOSS_CYCLES)) begin
        present_ff <= 1'b0;
      end else begin
        loss_cnt_ff <= loss_cnt_ff + 32'h0000_0001;
      end
      // tied pair reads equal and low for the whole window
      if (present_ff || key_dat != key_clk || key_clk) begin
        bridge_cnt_ff <= 16'h0000;
        bridged_ff <= 1'b0;
      end else if (bridge_cnt_ff == 16'(BRIDGE_CYC)) begin
        bridged_ff <= 1'b1;
      end else begin
        bridge_cnt_ff <= bridge_cnt_ff + 16'h0001;
      end
    end
  end
  wire unplug = present_ff & ~frame_ff & (loss_cnt_ff == 32'(LOSS_CYCLES));

  // debounce: a key pattern counts once two frames agree
  logic [8:0] last_ff, keys_ff;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      last_ff <= 9'h000;
      keys_ff <= 9'h000;
    end else if (!present_ff) begin
      last_ff <= 9'h000;
      keys_ff <= 9'h000;
    end else if (frame_ff) begin
      last_ff <= shift_ff;
      if (shift_ff == last_ff) begin
        keys_ff <= shift_ff;
      end
    end
  end

  // combination window: keys seen in the window are OR-ed then decoded
  key_state_t kst_ff;
  logic [8:0] acc_ff;
  logic [15:0] win_cnt_ff;
  logic fire, release_ev;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      kst_ff <= KS_IDLE;
      acc_ff <= 9'h000;
      win_cnt_ff <= 16'h0000;
    end else begin
      unique case (kst_ff)
        KS_IDLE: begin
          if (keys_ff != 9'h000) begin
            acc_ff <= keys_ff;
            win_cnt_ff <= 16'h0000;
            kst_ff <= KS_COLLECT;
          end
        end
        KS_COLLECT: begin
          acc_ff <= acc_ff | keys_ff;
          win_cnt_ff <= win_cnt_ff + 16'h0001;
          if (keys_ff == 9'h000) begin
            kst_ff <= KS_IDLE;
          end else if (win_cnt_ff == 16'(COMBO_CYC - 1)) begin
            kst_ff <= KS_HELD;
          end
        end
        KS_HELD: begin
          if (keys_ff == 9'h000) begin
            kst_ff <= KS_IDLE;
          end
        end
      endcase
    end
  end
  // decode at window end, or at release if keys let go inside the window
  assign fire = (kst_ff == KS_COLLECT) &&
                (keys_ff == 9'h000 || win_cnt_ff == 16'(COMBO_CYC - 1));
  assign release_ev = (kst_ff != KS_IDLE) && (keys_ff == 9'h000);

  // software registers
  logic [5:0] ctrl_ff;
  logic [7:0] speed_ff;
  logic [23:0] limits_ff;
  logic ack_ff;
  logic unload_clr;
  wire wr_go = avs_write_in & ack_ff;
  wire [7:0] oper_lim = limits_ff[7:0];
  wire [7:0] lift_lim = limits_ff[15:8];
  wire [7:0] return_spd = limits_ff[23:16];
  wire speed_ok = speed_ff <= oper_lim;
  wire lift_ok = speed_ff <= lift_lim;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // byte-lane merged write words for each writable register
  wire [31:0] ctrl_wr = merge({26'h0, ctrl_ff}, avs_writedata_in,
                              avs_byteenable_in);
  wire [31:0] speed_wr = merge({24'h0, speed_ff}, avs_writedata_in,
                               avs_byteenable_in);
  wire [31:0] limits_wr = merge({8'h0, limits_ff}, avs_writedata_in,
                                avs_byteenable_in);

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ctrl_ff <= CTRL_RESET;
      speed_ff <= 8'h00;
      limits_ff <= LIMITS_RESET;
    end else begin
      if (wr_go && avs_address_in == REG_CTRL) begin
        ctrl_ff <= ctrl_wr[5:0];
      end else if (unload_clr) begin
        ctrl_ff[CTRL_UNLOAD] <= 1'b0;
      end
      if (wr_go && avs_address_in == REG_SPEED) begin
        speed_ff <= speed_wr[7:0];
      end
      if (wr_go && avs_address_in == REG_LIMITS) begin
        limits_ff <= limits_wr[23:0];
      end
    end
  end

  // levelling control state
  logic [2:0] presel_ff;
  logic [1:0] cur_dl_ff;
  logic [7:0] ref_ff;
  logic busy_ff, raise_ff, lower_ff, trac_ff, auto_ff, stby_ff, dl1_ff;
  logic [8:0] ev_keys_ff;
  cmd_t cmd_ff;
  logic save1, save2;
  wire any_presel = |presel_ff;
  wire levels_ok = ctrl_ff[CTRL_LEVELS_EN] & any_presel;
  wire auto_par = ctrl_ff[CTRL_AUTO_LIFT];
  wire keep_move = ctrl_ff[CTRL_LATE_FW] & busy_ff;
  wire unplug_stop = unplug & ~keep_move;
  wire single = $onehot(acc_ff);
  wire key_stop = fire && (acc_ff == KM_STOP ||
                  (!single && acc_ff != (KM_FRONT | KM_REAR) &&
                   acc_ff != (KM_STOP | KM_M1) &&
                   acc_ff != (KM_STOP | KM_M2) &&
                   acc_ff != (KM_M1 | KM_DL) && acc_ff != (KM_M2 | KM_DL) &&
                   acc_ff != (KM_DL | KM_RAISE)));
  wire do_stop = key_stop | unplug_stop;
  logic [7:0] slot1_ff, slot2_ff;
  assign save1 = fire && acc_ff == (KM_STOP | KM_M1);
  assign save2 = fire && acc_ff == (KM_STOP | KM_M2);
  assign unload_clr = fire && (acc_ff == KM_RAISE || acc_ff == KM_LOWER) &&
                      !presel_ff[K_LIFT] && any_presel && speed_ok;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      presel_ff <= 3'h0;
      cur_dl_ff <= 2'h1;
      ref_ff <= 8'h00;
      busy_ff <= 1'b0;
      raise_ff <= 1'b0;
      lower_ff <= 1'b0;
      trac_ff <= 1'b0;
      auto_ff <= 1'b0;
      stby_ff <= 1'b0;
      dl1_ff <= 1'b0;
      ev_keys_ff <= 9'h000;
      cmd_ff <= '0;
    end else begin
      cmd_ff <= '0;
      if (level_done_in) begin
        busy_ff <= 1'b0; // started process ran to completion
      end
      if (release_ev) begin
        raise_ff <= 1'b0;
        lower_ff <= 1'b0;
        if (acc_ff == KM_DL && levels_ok) begin
          cmd_ff <= '{1'b1, OP_DRIVE_LEVEL, {6'h0, cur_dl_ff}};
          busy_ff <= 1'b1;
        end
      end
      if (fire) begin
        ev_keys_ff <= acc_ff;
      end
      if (ign_fall && keys_ff[K_STOP]) begin
        stby_ff <= 1'b1;
        cmd_ff <= '{1'b1, OP_STANDBY, 8'h00};
      end else if (ign_rise) begin
        stby_ff <= 1'b0;
        dl1_ff <= 1'b0;
      end else if (do_stop) begin
        busy_ff <= 1'b0;
        raise_ff <= 1'b0;
        lower_ff <= 1'b0;
        trac_ff <= 1'b0;
        ref_ff <= level_in;
        cmd_ff <= '{1'b1, OP_STOP, level_in};
      end else if (fire) begin
        if (acc_ff == (KM_FRONT | KM_REAR)) begin
          presel_ff <= 3'b011;
        end else if (acc_ff == KM_FRONT || acc_ff == KM_REAR ||
                     acc_ff == KM_LIFT) begin
          if (|(presel_ff & acc_ff[2:0])) begin
            presel_ff <= 3'h0;
          end else begin
            presel_ff <= presel_ff | acc_ff[2:0];
          end
        end else if (save1 || save2) begin
          cmd_ff <= '{1'b1, OP_MEM_STORE, {7'h0, save2}};
        end else if (acc_ff == (KM_M1 | KM_DL) ||
                     acc_ff == (KM_M2 | KM_DL) ||
                     acc_ff == (KM_DL | KM_RAISE)) begin
          if (levels_ok) begin
            cur_dl_ff <= acc_ff[K_M1] ? 2'h1 : acc_ff[K_M2] ? 2'h2 : 2'h3;
            busy_ff <= 1'b1;
            cmd_ff <= '{1'b1, OP_DRIVE_LEVEL,
                        acc_ff[K_M1] ? 8'h01 : acc_ff[K_M2] ? 8'h02 : 8'h03};
          end
        end else if (acc_ff == KM_M1 && presel_ff == KM_LIFT[2:0]) begin
          if (auto_par) begin
            trac_ff <= 1'b1;
            cmd_ff <= '{1'b1, OP_TRACTION_ON, 8'h00};
          end
        end else if (acc_ff == KM_M1 || acc_ff == KM_M2) begin
          if (any_presel && speed_ok) begin
            busy_ff <= 1'b1;
            cmd_ff <= '{1'b1, OP_MEM_RECALL,
                        acc_ff[K_M1] ? slot1_ff : slot2_ff};
          end
        end else if (acc_ff == KM_RAISE || acc_ff == KM_LOWER) begin
          if (presel_ff[K_LIFT]) begin
            if (lift_ok) begin
              if (acc_ff == KM_LOWER) begin
                auto_ff <= 1'b0;
                cmd_ff <= '{1'b1, OP_LIFT_DOWN, 8'h00};
              end else if (auto_par) begin
                auto_ff <= 1'b1;
                cmd_ff <= '{1'b1, OP_AUTO_ON, 8'h00};
              end else begin
                cmd_ff <= '{1'b1, OP_LIFT_UP, 8'h00};
              end
            end
          end else if (any_presel && speed_ok) begin
            raise_ff <= acc_ff[K_RAISE];
            lower_ff <= acc_ff[K_LOWER];
          end
        end
      end else if (ign_on && !dl1_ff &&
                   (bridged_ff || speed_ff > return_spd)) begin
        dl1_ff <= 1'b1;
        cur_dl_ff <= 2'h1;
        busy_ff <= 1'b1;
        cmd_ff <= '{1'b1, OP_DRIVE_LEVEL, 8'h01};
      end
    end
  end

  // memory slots carry no reset so they outlive ignition-off
  always_ff @(posedge sys_clk_in) begin
    if (save1 && !do_stop) begin
      slot1_ff <= ref_ff;
    end
    if (save2 && !do_stop) begin
      slot2_ff <= ref_ff;
    end
  end

  // warning lamp with flash divider
  logic [31:0] flash_cnt_ff;
  logic flash_ff, lamp_ff;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      flash_cnt_ff <= 32'h0000_0000;
      flash_ff <= 1'b0;
      lamp_ff <= 1'b0;
    end else begin
      if (flash_cnt_ff == 32'(FLASH_CYCLES - 1)) begin
        flash_cnt_ff <= 32'h0000_0000;
        flash_ff <= ~flash_ff;
      end else begin
        flash_cnt_ff <= flash_cnt_ff + 32'h0000_0001;
      end
      if (ctrl_ff[CTRL_SYS_FAIL]) begin
        lamp_ff <= flash_ff;
      end else begin
        lamp_ff <= ctrl_ff[CTRL_DL_FAULT];
      end
    end
  end

  // bus slave: one wait cycle, read data loaded while waitrequest is high
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ack_ff <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      ack_ff <= (avs_read_in | avs_write_in) & ~ack_ff;
      if (avs_read_in && !ack_ff) begin
        unique case (avs_address_in)
          REG_CTRL: avs_readdata_out <= {26'h0, ctrl_ff};
          REG_SPEED: avs_readdata_out <= {24'h0, speed_ff};
          REG_LIMITS: avs_readdata_out <= {8'h0, limits_ff};
          REG_STATUS: avs_readdata_out <= {19'h0, lower_ff, raise_ff,
            busy_ff, bridged_ff, present_ff, stby_ff, trac_ff, auto_ff,
            cur_dl_ff, presel_ff};
          REG_MEM: avs_readdata_out <= {8'h0, ref_ff, slot2_ff, slot1_ff};
          REG_EVENT: avs_readdata_out <= {19'h0, ev_keys_ff, cmd_ff.op};
          default: avs_readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_ff;

  // registered outputs
  assign cmd_out = cmd_ff;
  assign preselect_lamp_out = presel_ff;
  assign raise_hold_out = raise_ff;
  assign lower_hold_out = lower_ff;
  assign traction_out = trac_ff;
  assign auto_lift_out = auto_ff;
  assign standby_out = stby_ff;
  assign warning_lamp_out = lamp_ff;
endmodule : suspension_remote_command_decoder

// *** dv/remote_cmd_props.sv ***
// port checker for the remote keypad command decoder
module remote_cmd_props
  import remote_cmd_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire cmd_t cmd_out,
  input wire logic raise_hold_out,
  input wire logic lower_hold_out,
  input wire logic traction_out,
  input wire logic auto_lift_out,
  input wire logic standby_out
);
  default clocking dcb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic req;
  op_t op_seen;
  // bus request and the command issued this cycle
  assign req = avs_read_in | avs_write_in;
  assign op_seen = cmd_out.valid ? cmd_out.op : OP_NONE;
  // a new request always waits one cycle, never more
  a_first_wait: assert property (req && !$past(req) |-> avs_waitrequest_out)
    else $error("new request not held off");
  a_one_wait: assert property (
    req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("wait longer than one cycle");
  // command outcomes at the ports
  a_hold_excl: assert property (
    !(raise_hold_out && lower_hold_out))
    else $error("raise and lower held together");
  a_level_code: assert property (
    op_seen == OP_DRIVE_LEVEL |-> cmd_out.arg inside {8'h01, 8'h02, 8'h03})
    else $error("driving level out of range");
  a_auto_set: assert property (
    op_seen == OP_AUTO_ON |-> ##[0:2] auto_lift_out)
    else $error("auto lift not set");
  a_traction_set: assert property (
    op_seen == OP_TRACTION_ON |-> ##[0:2] traction_out)
    else $error("traction help not set");
  a_stop_traction: assert property (
    op_seen == OP_STOP |-> ##[0:2] !traction_out)
    else $error("stop left traction help on");
  a_standby_set: assert property (
    op_seen == OP_STANDBY |-> ##[0:2] standby_out)
    else $error("standby not entered");
  c_traction: cover property (op_seen == OP_TRACTION_ON);
  c_standby: cover property (op_seen == OP_STANDBY);
  c_recall: cover property (op_seen == OP_MEM_RECALL);
endmodule : remote_cmd_props

bind suspension_remote_command_decoder remote_cmd_props u_props (
  .sys_clk_in, .rst_n_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out,
  .cmd_out, .raise_hold_out, .lower_hold_out, .traction_out, .auto_lift_out,
  .standby_out);

// *** dv/keypad_model.sv ***
// keypad partner model driving the data and clock lines
module keypad_model
  import remote_cmd_pkg::*;
(
  input wire logic plugged_in,
  input wire logic [KEY_BITS-1:0] keys_in,
  output logic data_out,
  output logic clk_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [KEY_BITS-1:0] frame;
  // sole keypad on the line: frames lowest key first, clock idle low
  initial begin
    data_out = 1'b0;
    clk_out = 1'b0;
    forever begin
      frame = keys_in;
      for (int i = 0; i < KEY_BITS && plugged_in; i++) begin
        data_out = frame[i];
        #80 clk_out = 1'b1;
        #80 clk_out = 1'b0;
      end
      // clock stands still between frames; a loose data line wanders
      #320 data_out = ~data_out;
    end
  end
endmodule : keypad_model

// *** dv/test_suspension_remote_command_decoder.sv ***
// self-checking bench for the remote keypad command decoder
module test_suspension_remote_command_decoder
  import remote_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, rd, wr, ign, plug, bridge, kp_data, kp_clk;
  logic wait_req, raise_h, lower_h, tract, auto_l, stby, warn;
  logic [7:0] addr;
  logic [31:0] wdata, rd_out, rdata;
  logic [KEY_BITS-1:0] keys;
  logic [2:0] lamps;
  cmd_t cmd;
  int failures, num_checks;
  localparam logic [8:0] F = 9'h001, LFT = 9'h004, UP = 9'h008, DN = 9'h010;
  localparam logic [8:0] STP = 9'h020, M1 = 9'h040, M2 = 9'h080, DL = 9'h100;
  // bridging ties the data pin to the keypad clock
  suspension_remote_command_decoder #(.LOSS_CYCLES(400), .FLASH_CYCLES(8))
    u_dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rd_out),
    .avs_waitrequest_out(wait_req), .keypad_data_in(bridge ? kp_clk : kp_data),
    .keypad_clk_in(kp_clk), .ignition_in(ign), .level_in(8'h5A),
    .level_done_in(1'b0), .cmd_out(cmd), .preselect_lamp_out(lamps),
    .raise_hold_out(raise_h), .lower_hold_out(lower_h), .traction_out(tract),
    .auto_lift_out(auto_l), .standby_out(stby), .warning_lamp_out(warn));
  keypad_model u_keypad (.plugged_in(plug), .keys_in(keys), .data_out(kp_data),
    .clk_out(kp_clk));
  // verdict and end of run
  task automatic end_sim;
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  // count a comparison and report a mismatch
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one bus transfer, held until waitrequest is low at an edge
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge sys_clk);
    end while (wait_req !== 1'b0);
    rdata = rd_out;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  // wait for the next command; arg FF means arg not compared
  task automatic expect_cmd(op_t op, logic [7:0] arg, int lim);
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (cmd.valid !== 1'b1 && n < lim);
    chk("op", op, cmd.valid === 1'b1 ? cmd.op : OP_NONE);
    if (arg !== 8'hFF) chk("arg", arg, cmd.arg);
  endtask : expect_cmd
  // press a key set, release it, then check what is decoded
  task automatic key_cmd(logic [8:0] k, op_t op, logic [7:0] arg);
    @(posedge sys_clk);
    keys <= k;
    repeat (1200) @(posedge sys_clk);
    keys <= '0;
    expect_cmd(op, arg, 3000);
  endtask : key_cmd
  task automatic t_regs;
    bus(1'b0, REG_LIMITS, 32'h0);
    chk("limits", {8'h00, LIMITS_RESET}, rdata);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rdata);
    bus(1'b1, REG_CTRL, 32'h3);
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", 32'h3, rdata);
  endtask : t_regs
  task automatic t_lift;
    key_cmd(LFT, OP_NONE, 8'hFF);
    chk("lamps", 3'h4, lamps);
    key_cmd(UP, OP_AUTO_ON, 8'hFF);
    key_cmd(DN, OP_LIFT_DOWN, 8'hFF);
    chk("auto", 1'h0, auto_l);
    key_cmd(M1, OP_TRACTION_ON, 8'hFF);
    key_cmd(LFT, OP_NONE, 8'hFF);
    chk("lamps", 3'h0, lamps);
    key_cmd(STP, OP_STOP, 8'h5A);
    chk("traction", 1'h0, tract);
  endtask : t_lift
  task automatic t_levels;
    logic [8:0] combo [3];
    combo = '{M1 | DL, M2 | DL, DL | UP};
    key_cmd(F, OP_NONE, 8'hFF);
    for (int i = 0; i < 3; i++) begin
      key_cmd(combo[i], OP_DRIVE_LEVEL, 8'(i + 1));
    end
    key_cmd(DL, OP_DRIVE_LEVEL, 8'h03);
  endtask : t_levels
  task automatic t_memory;
    key_cmd(STP | M1, OP_MEM_STORE, 8'h00);
    key_cmd(STP | M2, OP_MEM_STORE, 8'h01);
    bus(1'b1, REG_SPEED, 32'hA);
    key_cmd(M2, OP_MEM_RECALL, 8'hFF);
    bus(1'b1, REG_SPEED, 32'hB);
    expect_cmd(OP_DRIVE_LEVEL, 8'h01, 5);
    key_cmd(M1, OP_NONE, 8'hFF);
    bus(1'b1, REG_SPEED, 32'h0);
  endtask : t_memory
  task automatic t_stop;
    key_cmd(UP | DN, OP_STOP, 8'h5A);
    @(posedge sys_clk);
    keys <= STP;
    expect_cmd(OP_STOP, 8'h5A, 6000);
    @(posedge sys_clk);
    ign <= 1'b0;
    expect_cmd(OP_STANDBY, 8'hFF, 200);
    repeat (3) @(negedge sys_clk);
    chk("standby", 1'h1, stby);
    @(posedge sys_clk);
    keys <= '0;
    ign <= 1'b1;
    repeat (1000) @(posedge sys_clk);
  endtask : t_stop
  task automatic t_unplug;
    plug <= 1'b0;
    expect_cmd(OP_STOP, 8'h5A, 1500);
    @(posedge sys_clk);
    ign <= 1'b0;
    bridge <= 1'b1;
    repeat (3000) @(posedge sys_clk);
    ign <= 1'b1;
    expect_cmd(OP_DRIVE_LEVEL, 8'h01, 3000);
  endtask : t_unplug
  task automatic t_warn;
    logic w1;
    bus(1'b1, REG_CTRL, 32'h13);
    repeat (5) @(negedge sys_clk);
    chk("warn", 1'h1, warn);
    bus(1'b1, REG_CTRL, 32'h8);
    repeat (5) @(negedge sys_clk);
    w1 = warn;
    repeat (8) @(negedge sys_clk);
    chk("flash", {31'h0, ~w1}, warn);
    bus(1'b1, REG_CTRL, 32'h0);
    repeat (5) @(negedge sys_clk);
    chk("warn", 1'h0, warn);
  endtask : t_warn
  // 200 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // watchdog cuts a hung run short
  initial begin
    repeat (100000) @(posedge sys_clk);
    failures++;
    end_sim();
  end
  // reset, then the scenarios in turn
  initial begin
    {rst_n, rd, wr, bridge, addr, wdata, keys} = 0;
    ign = 1'b1;
    plug = 1'b1;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_lift();
    t_levels();
    t_memory();
    t_stop();
    t_unplug();
    t_warn();
    end_sim();
  end
endmodule : test_suspension_remote_command_decoder
